// >>> adcsq_clkdiv.sv
// Converter clock tick generator
`timescale 1ns/100ps
module adcsq_clkdiv (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [2:0] ratio_m1,
  output logic            tick
);
  logic [2:0] cnt_reg;
  wire        wrap = (cnt_reg >= ratio_m1);

  // Free-running counter; tick marks one converter clock period
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_reg <= 3'h0;
      tick    <= 1'b0;
    end else if (ce) begin
      cnt_reg <= wrap ? 3'h0 : cnt_reg + 3'h1;
      tick    <= wrap;
    end
  end
endmodule

// >>> adcsq_core_model.sv
// Behavioural analog core model: returns a code made from the selected pin
`timescale 1ns/100ps
module adcsq_core_model (
  input  wire logic       clk_sys,
  input  wire logic       core_sample,
  input  wire logic [4:0] core_pin,
  input  wire logic [9:0] salt,
  output logic      [9:0] core_result
);
  logic       held_reg = 1'b0;
  logic [9:0] code_reg = 10'h155;
  // Toggles until the first sample so a stray early capture is visible
  always_ff @(posedge clk_sys) begin
    if (core_sample) held_reg <= 1'b1;
    if (held_reg || core_sample) code_reg <= salt ^ {5'h00, core_pin};
    else code_reg <= ~code_reg;
  end
  assign core_result = code_reg;
endmodule

// >>> adcsq_pinsel.sv
// Input pin selector: maps channel, amplifier path and port group to a pin
`timescale 1ns/100ps
module adcsq_pinsel (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       load,
  input  wire logic [2:0] channel,
  input  wire logic [1:0] amp_path,
  input  wire logic [1:0] port_group,
  output logic [4:0]      pin
);
  // Pins 0-4 base, 8-15 port A, 16-23 port B, 24/25 extended inputs
  wire       ext_sel = (amp_path == 2'h1) || (amp_path == 2'h2);
  wire [4:0] ext_pin = (amp_path == 2'h1) ? 5'h18 : 5'h19;
  wire [4:0] grp_pin = (port_group == 2'h0) ? {2'h0, channel} :
                       (port_group == 2'h1) ? {2'h1, channel} :
                                              {2'h2, channel};

  // Latched at conversion start so mid-conversion edits do not move it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin <= 5'h00;
    end else if (ce && load) begin
      pin <= ext_sel ? ext_pin : grp_pin;
    end
  end
endmodule

// >>> adcsq_pkg.sv
// Package: register map, field positions, reset values and enums
package adcsq_pkg;
  // Byte addresses of the registers (one aligned word each)
  localparam logic [7:0] ADDR_CTRL_0   = 8'h00;
  localparam logic [7:0] ADDR_CTRL_1   = 8'h04;
  localparam logic [7:0] ADDR_CTRL_2   = 8'h08;
  localparam logic [7:0] ADDR_CTRL_3   = 8'h0c;
  localparam logic [7:0] ADDR_TEST     = 8'h10;
  localparam logic [7:0] ADDR_IRQ      = 8'h14;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;
  localparam logic [7:0] ADDR_RESULT_0 = 8'h20;
  localparam logic [7:0] ADDR_RESULT_7 = 8'h3c;

  // conv_ctrl_0 fields
  localparam int CH_LSB       = 0;
  localparam int MODE_LSB     = 3;
  localparam int TRIG_EN_BIT  = 5;
  localparam int START_BIT    = 6;
  localparam int CKSA_BIT     = 7;
  // conv_ctrl_1 fields
  localparam int CKSB_BIT     = 0;
  localparam int VREF_BIT     = 1;
  localparam int AMP_LSB      = 2;
  localparam int SCAN_LSB     = 4;
  // conv_ctrl_2 fields
  localparam int SMP_BIT      = 0;
  localparam int GRP_LSB      = 1;
  localparam int TRGSRC_LSB   = 3;
  // conv_ctrl_3 fields
  localparam int DMA_BIT      = 0;
  localparam int CKSC_BIT     = 1;

  localparam logic [7:0] CTRL_RST = 8'h00;

  // Last tick count of a conversion; a conversion lasts this plus one converter clock ticks
  localparam logic [5:0] CONV_TICKS = 6'h3b;

  // Operating modes
  localparam logic [1:0] MODE_ONESHOT = 2'h0;
  localparam logic [1:0] MODE_REPEAT  = 2'h1;
  localparam logic [1:0] MODE_SWEEP   = 2'h2;

  // Trigger sources
  localparam logic [1:0] TSRC_PIN  = 2'h0;
  localparam logic [1:0] TSRC_TMRB = 2'h1;
  localparam logic [1:0] TSRC_TMRA = 2'h2;

  typedef enum logic [2:0] {
    ADCSQ_IDLE = 3'b001,
    ADCSQ_ARM  = 3'b010,
    ADCSQ_CONV = 3'b100
  } adcsq_state_e;

  // Divider ratio minus one from the three select bits
  function automatic logic [2:0] div_code(input logic a, input logic b,
                                          input logic c);
    logic [2:0] r;
    r = 3'h0;
    if (c) begin
      r = b ? 3'h5 : 3'h7;
    end else begin
      unique case ({a, b})
        2'b00: r = 3'h3;
        2'b01: r = 3'h2;
        2'b10: r = 3'h1;
        2'b11: r = 3'h0;
      endcase
    end
    return r;
  endfunction
endpackage

// >>> adcsq_top.sv
// Converter sequencer control with AXI4-Lite register slave
//
// Contract
// - Three select bits choose six converter clock divisors
// - Control rewrite mid-conversion may corrupt result
// - Sweep group select honoured only in sweep modes; here the group bits pick the port in every mode
// - DMA mode stores every result in first register
// - Result read during DMA may be undefined
// - One-shot converts once, repeat converts continuously
// - Start bit or selected trigger starts conversion; here a sweep mode code never starts one
// - Clearing start bit stops conversion in all modes
// - One-shot raises request at conversion completion
// - Repeat requests only when DMA mode enabled
// - Non-DMA results go to matching channel register; here extended pins 24/25 write result slots 0/1
// - Pin chosen from channel, amplifier, group fields
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module adcsq_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ext_trigger_pin,
  input  wire logic        timer_b_irq,
  input  wire logic        timer_a_irq,
  input  wire logic [9:0]  core_result,
  output logic             core_sample,
  output logic [4:0]       core_pin,
  output logic             core_vref_on,
  output logic             conv_irq,
  output logic             dma_req
);
  //////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0]   ctrl0_reg;
  logic [7:0]   ctrl1_reg;
  logic [7:0]   ctrl2_reg;
  logic [7:0]   ctrl3_reg;
  logic [7:0]   test_reg;
  logic         irq_flag_reg;
  logic [9:0]   result_mem [0:7];
  adcsq_pkg::adcsq_state_e state_reg;
  logic [5:0]   tick_cnt_reg;
  logic         trig_pin_d_reg;
  logic         aw_hold_reg;
  logic         w_hold_reg;
  logic [7:0]   awaddr_reg;
  logic [31:0]  wdata_reg;
  logic [3:0]   wstrb_reg;

  //////////////////////////////////////////////////////////////////////////
  // Field decode
  wire [2:0] channel    = ctrl0_reg[adcsq_pkg::CH_LSB +: 3];
  wire [1:0] mode       = ctrl0_reg[adcsq_pkg::MODE_LSB +: 2];
  wire       trig_en    = ctrl0_reg[adcsq_pkg::TRIG_EN_BIT];
  wire       start_bit  = ctrl0_reg[adcsq_pkg::START_BIT];
  wire [1:0] amp_path   = ctrl1_reg[adcsq_pkg::AMP_LSB +: 2];
  wire [1:0] trg_src    = ctrl2_reg[adcsq_pkg::TRGSRC_LSB +: 2];
  wire [1:0] port_group = ctrl2_reg[adcsq_pkg::GRP_LSB +: 2];
  wire       dma_mode   = ctrl3_reg[adcsq_pkg::DMA_BIT];
  wire       is_sweep   = (mode == adcsq_pkg::MODE_SWEEP);
  // Sweep modes are not built here; the group bits select the port in every mode
  wire [1:0] eff_group  = port_group;
  wire [2:0] div_m1 = adcsq_pkg::div_code(
                        ctrl0_reg[adcsq_pkg::CKSA_BIT],
                        ctrl1_reg[adcsq_pkg::CKSB_BIT],
                        ctrl3_reg[adcsq_pkg::CKSC_BIT]);
  wire       tick;
  wire [4:0] pin_sel;

  //////////////////////////////////////////////////////////////////////////
  // Trigger selection; external pin triggers on a falling edge
  // The pin delay flop resets high, matching the idle level, so no false
  // falling edge is seen straight after reset
  wire pin_fall = trig_pin_d_reg && !ext_trigger_pin;
  wire hw_trig  = (trg_src == adcsq_pkg::TSRC_PIN)  ? pin_fall :
                  (trg_src == adcsq_pkg::TSRC_TMRB) ? timer_b_irq :
                  (trg_src == adcsq_pkg::TSRC_TMRA) ? timer_a_irq :
                                                      1'b0;
  // Sweep modes never start here, so a stray sweep code stays in the armed state
  wire go       = start_bit && !is_sweep &&
                  (!trig_en || hw_trig);

  //////////////////////////////////////////////////////////////////////////
  // Converter clock divider and pin selector
  // The divider runs free; a conversion may start anywhere in its period,
  // so its length varies by up to one converter clock
  adcsq_clkdiv u_div (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .ratio_m1 (div_m1),
    .tick     (tick)
  );

  // Pin is captured whenever go is seen outside a conversion, in idle or armed
  wire load_pin = (state_reg != adcsq_pkg::ADCSQ_CONV) && go;

  adcsq_pinsel u_pin (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .ce         (ce),
    .load       (load_pin),
    .channel    (channel),
    .amp_path   (amp_path),
    .port_group (eff_group),
    .pin        (pin_sel)
  );

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order
  // Only byte lane 0 carries register bits; upper lanes are ignored
  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire aw_have  = aw_hold_reg || aw_take;
  wire w_have   = w_hold_reg || w_take;
  wire wr_fire  = aw_have && w_have && !s_axi_bvalid;
  wire [7:0]  wr_addr = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_reg ? wdata_reg : s_axi_wdata;
  wire [3:0]  wr_strb = w_hold_reg ? wstrb_reg : s_axi_wstrb;
  wire        wr_lane = wr_fire && wr_strb[0];
  wire        wr_c0   = wr_lane && (wr_addr == adcsq_pkg::ADDR_CTRL_0);
  wire        wr_c1   = wr_lane && (wr_addr == adcsq_pkg::ADDR_CTRL_1);
  wire        wr_c2   = wr_lane && (wr_addr == adcsq_pkg::ADDR_CTRL_2);
  wire        wr_c3   = wr_lane && (wr_addr == adcsq_pkg::ADDR_CTRL_3);
  wire        wr_tst  = wr_lane && (wr_addr == adcsq_pkg::ADDR_TEST);
  wire        wr_irq  = wr_lane && (wr_addr == adcsq_pkg::ADDR_IRQ);
  wire        wr_ok   = (wr_addr <= adcsq_pkg::ADDR_IRQ) &&
                        (wr_addr[1:0] == 2'h0);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else if (ce) begin
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      aw_hold_reg   <= aw_have && !wr_fire;
      w_hold_reg    <= w_have && !wr_fire;
      s_axi_awready <= !aw_have && !s_axi_bvalid && !wr_fire;
      s_axi_wready  <= !w_have && !s_axi_bvalid && !wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  wire done      = (state_reg == adcsq_pkg::ADCSQ_CONV) && tick &&
                   (tick_cnt_reg == adcsq_pkg::CONV_TICKS);
  wire stop_sw   = wr_c0 && !wr_data[adcsq_pkg::START_BIT];
  wire one_shot  = (mode == adcsq_pkg::MODE_ONESHOT);
  // Software trigger in one-shot clears the start bit on completion
  wire self_clr  = done && one_shot && !trig_en;
  wire irq_event = done && (one_shot || dma_mode);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg    <= adcsq_pkg::ADCSQ_IDLE;
      tick_cnt_reg <= 6'h00;
      core_sample  <= 1'b0;
    end else if (ce) begin
      core_sample <= 1'b0;
      unique case (state_reg)
        adcsq_pkg::ADCSQ_IDLE: begin
          if (start_bit) begin
            state_reg <= adcsq_pkg::ADCSQ_ARM;
          end
        end
        adcsq_pkg::ADCSQ_ARM: begin
          if (!start_bit) begin
            state_reg <= adcsq_pkg::ADCSQ_IDLE;
          end else if (go) begin
            state_reg    <= adcsq_pkg::ADCSQ_CONV;
            tick_cnt_reg <= 6'h00;
            core_sample  <= 1'b1;
          end
        end
        adcsq_pkg::ADCSQ_CONV: begin
          if (!start_bit || stop_sw) begin
            state_reg <= adcsq_pkg::ADCSQ_IDLE;
          end else if (done) begin
            // Repeat mode rearms; one-shot waits for another start
            state_reg <= one_shot ? adcsq_pkg::ADCSQ_IDLE
                                  : adcsq_pkg::ADCSQ_ARM;
          end else if (tick) begin
            tick_cnt_reg <= tick_cnt_reg + 6'h01;
          end
        end
        default: begin
          state_reg <= adcsq_pkg::ADCSQ_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control registers; a rewrite mid-conversion is accepted as is
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl0_reg      <= adcsq_pkg::CTRL_RST;
      ctrl1_reg      <= adcsq_pkg::CTRL_RST;
      ctrl2_reg      <= adcsq_pkg::CTRL_RST;
      ctrl3_reg      <= adcsq_pkg::CTRL_RST;
      test_reg       <= adcsq_pkg::CTRL_RST;
      trig_pin_d_reg <= 1'b1;
    end else if (ce) begin
      trig_pin_d_reg <= ext_trigger_pin;
      if (wr_c0) begin
        ctrl0_reg <= wr_data[7:0];
      end else if (self_clr) begin
        ctrl0_reg[adcsq_pkg::START_BIT] <= 1'b0;
      end
      if (wr_c1) begin
        ctrl1_reg <= wr_data[7:0];
      end
      if (wr_c2) begin
        ctrl2_reg <= wr_data[7:0];
      end
      if (wr_c3) begin
        ctrl3_reg <= wr_data[7:0];
      end
      if (wr_tst) begin
        test_reg <= wr_data[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt request flag: a new event wins over a software clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_flag_reg <= 1'b0;
      conv_irq     <= 1'b0;
      dma_req      <= 1'b0;
      core_pin     <= 5'h00;
      core_vref_on <= 1'b0;
    end else if (ce) begin
      if (irq_event) begin
        irq_flag_reg <= 1'b1;
      end else if (wr_irq && !wr_data[0]) begin
        irq_flag_reg <= 1'b0;
      end
      conv_irq     <= irq_flag_reg;
      dma_req      <= irq_event && dma_mode;
      core_pin     <= pin_sel;
      core_vref_on <= ctrl1_reg[adcsq_pkg::VREF_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Result storage; the array is not reset
  // Software must not trust a slot until a conversion has filled it
  wire [2:0] res_idx = dma_mode ? 3'h0 : pin_sel[2:0];

  always_ff @(posedge clk_sys) begin
    if (ce && done) begin
      result_mem[res_idx] <= core_result;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path; one cycle from address to data
  wire        ar_take = s_axi_arvalid && s_axi_arready;
  wire        rd_res  = (s_axi_araddr >= adcsq_pkg::ADDR_RESULT_0) &&
                        (s_axi_araddr <= adcsq_pkg::ADDR_RESULT_7);
  wire [7:0]  status  = {5'h00, state_reg};
  wire [31:0] rd_word =
    (s_axi_araddr == adcsq_pkg::ADDR_CTRL_0) ? {24'h0, ctrl0_reg} :
    (s_axi_araddr == adcsq_pkg::ADDR_CTRL_1) ? {24'h0, ctrl1_reg} :
    (s_axi_araddr == adcsq_pkg::ADDR_CTRL_2) ? {24'h0, ctrl2_reg} :
    (s_axi_araddr == adcsq_pkg::ADDR_CTRL_3) ? {24'h0, ctrl3_reg} :
    (s_axi_araddr == adcsq_pkg::ADDR_TEST)   ? {24'h0, test_reg} :
    (s_axi_araddr == adcsq_pkg::ADDR_IRQ)    ? {31'h0, irq_flag_reg} :
    (s_axi_araddr == adcsq_pkg::ADDR_STATUS) ? {24'h0, status} :
    rd_res ? {22'h0, result_mem[s_axi_araddr[4:2]]} :
    32'h0000_0000;
  wire        rd_ok   = rd_res || (s_axi_araddr <= adcsq_pkg::ADDR_STATUS)
                        && (s_axi_araddr[1:0] == 2'h0);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok ? rd_word : 32'h0000_0000;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// >>> adcsq_top_asserts.sv
// Port checker for the converter sequencer, bound to its top module
`timescale 1ns/100ps
module adcsq_top_chk (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        core_sample,
  input wire logic [4:0]  core_pin,
  input wire logic        conv_irq,
  input wire logic        dma_req
);
  logic [9:0] since_reg;
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the last sample; saturates so long idles stay legal
  always_ff @(posedge clk_sys) begin
    if (rst) since_reg <= 10'h3ff;
    else if (core_sample) since_reg <= 10'h000;
    else if (since_reg != 10'h3ff) since_reg <= since_reg + 10'h001;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_spul; core_sample |=> !core_sample; endproperty
  a_spul: assert property (p_spul) else $error("long sample");
  property p_sgap; core_sample |-> since_reg >= 10'h03a; endproperty
  a_sgap: assert property (p_sgap) else $error("short conv");
  property p_irqt; $rose(conv_irq) |-> since_reg >= 10'h03a; endproperty
  a_irqt: assert property (p_irqt) else $error("early irq");
  // Measured at the request itself: repeat mode resamples right after it
  property p_dpul; dma_req |-> since_reg >= 10'h03a ##1 !dma_req;
  endproperty
  a_dpul: assert property (p_dpul) else $error("bad dma req");
  property p_pinst; core_sample |-> ##2 $stable(core_pin) [*8]; endproperty
  a_pinst: assert property (p_pinst) else $error("pin moved");
  property p_pinok;
    core_sample |-> ##2 (core_pin <= 5'h04 || core_pin inside {[8:25]});
  endproperty
  a_pinok: assert property (p_pinok) else $error("bad pin");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
endmodule
bind adcsq_top adcsq_top_chk u_chk (
  .clk_sys(clk_sys), .rst(rst), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .core_sample(core_sample),
  .core_pin(core_pin), .conv_irq(conv_irq), .dma_req(dma_req));

// >>> adcsq_top_tb.sv
// Self-checking bench for the converter sequencer control block
`timescale 1ns/100ps
module adcsq_top_tb;
  localparam int LIMIT = 30000;
  logic        clk_sys = 1'b0, rst = 1'b1, ce = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, ext_pin = 1'b1;
  logic        tmr_b = 1'b0, tmr_a = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [9:0]  salt = 10'h000, result;
  logic        awready, wready, bvalid, arready, rvalid, sample, vref_on;
  logic        irq, dreq;
  logic [1:0]  bresp, rresp;
  logic [4:0]  pin;
  int          mismatches = 0, n_compared = 0, cycles = 0;
  int          n_samp = 0, n_dreq = 0;
  adcsq_top uut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_trigger_pin(ext_pin),
    .timer_b_irq(tmr_b), .timer_a_irq(tmr_a), .core_result(result),
    .core_sample(sample), .core_pin(pin), .core_vref_on(vref_on),
    .conv_irq(irq), .dma_req(dreq));
  adcsq_core_model u_core (.clk_sys(clk_sys), .core_sample(sample),
    .core_pin(pin), .salt(salt), .core_result(result));
  ////////////////////////////////////////////////////////////////////////////
  initial forever #2 clk_sys = ~clk_sys;
  // Event counters and the hang limit
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (sample === 1'b1) n_samp <= n_samp + 1;
    if (dreq === 1'b1) n_dreq <= n_dreq + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_in(input string what, input int lo, hi, g);
    n_compared++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, g);
    end
  endtask
  // Write: address and data offered together, response hand-shaken late
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_sys);
      if (awvalid && awready) begin ad = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin wd = 1'b1; wvalid <= 1'b0; end
    end
    repeat ($urandom_range(2)) @(posedge clk_sys);
    bready <= 1'b1;
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic wr0(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    repeat ($urandom_range(2)) @(posedge clk_sys);
    rready <= 1'b1;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_irq(output int n);
    // Let a just-cleared flag drain out of the registered output first
    repeat (2) @(posedge clk_sys);
    n = 2;
    while (irq !== 1'b1 && n < 1000) begin @(posedge clk_sys); n++; end
  endtask
  task automatic fire(input int s);
    if (s == 0) ext_pin <= 1'b0;
    else if (s == 1) tmr_b <= 1'b1;
    else tmr_a <= 1'b1;
    @(posedge clk_sys);
    ext_pin <= 1'b1;
    tmr_b <= 1'b0;
    tmr_a <= 1'b0;
    @(posedge clk_sys);
  endtask
  function automatic int div_of(input logic [2:0] s);
    if (s[2]) return s[1] ? 6 : 8;
    return s[0] ? (s[1] ? 1 : 2) : (s[1] ? 3 : 4);
  endfunction
  function automatic logic [31:0] exp_res(input logic [4:0] p);
    return {22'h0, salt ^ {5'h00, p}};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0]  r, g;
    logic [2:0]  ch, s;
    int          n, n0;
    d = $urandom(56);
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    // Registers clear, bad addresses refused
    for (int i = 0; i < 6; i++) begin
      rd({3'h0, 3'(i), 2'b00}, d, r);
      chk("reset value", {24'h0, adcsq_pkg::CTRL_RST}, d);
    end
    rd(8'h40, d, r);
    chk("unmapped resp", 32'h2, {30'h0, r});
    wr(8'h02, 32'hff, r);
    chk("misaligned resp", 32'h2, {30'h0, r});
    $display("test registers done");
    // Reference on, then settle 1 us before any start
    wr0(adcsq_pkg::ADDR_CTRL_1, 32'h2);
    repeat (250) @(posedge clk_sys);
    chk("vref", 32'h1, {31'h0, vref_on});
    wr0(adcsq_pkg::ADDR_CTRL_2, 32'h1);
    wr0(adcsq_pkg::ADDR_TEST, 32'h3);
    rd(adcsq_pkg::ADDR_TEST, d, r);
    chk("test reg", 32'h3, d);
    // One-shot over every divider code, random group and channel
    for (int k = 0; k < 8; k++) begin
      s = 3'(k);
      g = 2'($urandom_range(2));
      ch = 3'($urandom_range(g == 2'h0 ? 4 : 7));
      salt <= 10'($urandom);
      n0 = n_samp;
      wr0(adcsq_pkg::ADDR_CTRL_3, {30'h0, s[2], 1'b0});
      wr0(adcsq_pkg::ADDR_CTRL_1, {30'h0, 1'b1, s[1]});
      wr0(adcsq_pkg::ADDR_CTRL_2, {29'h0, g, 1'b0});
      wr0(adcsq_pkg::ADDR_CTRL_0, {24'h0, s[0], 4'h8, ch});
      wait_irq(n);
      chk_in("conv cycles", 59 * div_of(s), 62 * div_of(s) + 12, n);
      chk("pin", {27'h0, 5'(8 * g) + 5'(ch)}, {27'h0, pin});
      rd(adcsq_pkg::ADDR_CTRL_0, d, r);
      chk("start bit", 32'h0, {31'h0, d[6]});
      rd(adcsq_pkg::ADDR_RESULT_0 + {3'h0, ch, 2'b00}, d, r);
      chk("result", exp_res(5'(8 * g) + 5'(ch)), d);
      wr0(adcsq_pkg::ADDR_IRQ, 32'h0);
      repeat (100) @(posedge clk_sys);
      chk("irq cleared", 32'h0, {31'h0, irq});
      chk_in("samples", 1, 1, n_samp - n0);
    end
    $display("test one-shot done");
    // Repeat without DMA: no request, stops on start clear
    wr0(adcsq_pkg::ADDR_CTRL_3, 32'h0);
    wr0(adcsq_pkg::ADDR_CTRL_1, 32'h3);
    wr0(adcsq_pkg::ADDR_CTRL_2, 32'h0);
    n0 = n_samp;
    wr0(adcsq_pkg::ADDR_CTRL_0, 32'hca);
    repeat (300) @(posedge clk_sys);
    chk("repeat irq", 32'h0, {31'h0, irq});
    chk_in("repeat samples", 3, 6, n_samp - n0);
    wr0(adcsq_pkg::ADDR_CTRL_0, 32'h8a);
    repeat (10) @(posedge clk_sys);
    n0 = n_samp;
    repeat (200) @(posedge clk_sys);
    chk_in("after stop", 0, 0, n_samp - n0);
    rd(adcsq_pkg::ADDR_RESULT_0 + 8'h08, d, r);
    chk("repeat result", exp_res(5'h02), d);
    chk_in("no dma req", 0, 0, n_dreq);
    $display("test repeat done");
    // Repeat with DMA mode: shared register, request per conversion
    ch = 3'($urandom_range(1, 4));
    salt <= 10'($urandom);
    wr0(adcsq_pkg::ADDR_CTRL_3, 32'h1);
    n0 = n_dreq;
    wr0(adcsq_pkg::ADDR_CTRL_0, {24'h0, 5'h19, ch});
    for (int i = 0; i < 3; i++) begin
      wait_irq(n);
      chk_in("dma conv", 0, 80, n);
      rd(adcsq_pkg::ADDR_RESULT_0, d, r);
      chk("shared result", exp_res({2'h0, ch}), d);
      wr0(adcsq_pkg::ADDR_IRQ, 32'h0);
    end
    wr0(adcsq_pkg::ADDR_CTRL_0, 32'h88);
    chk_in("dma pulses", 3, 4, n_dreq - n0);
    repeat (100) @(posedge clk_sys);
    wr0(adcsq_pkg::ADDR_CTRL_3, 32'h0);
    $display("test dma done");
    // Each trigger source; the other two are fired first and ignored
    for (int src = 0; src < 3; src++) begin
      wr0(adcsq_pkg::ADDR_CTRL_2, {27'h0, 2'(src), 3'h0});
      n0 = n_samp;
      wr0(adcsq_pkg::ADDR_CTRL_0, 32'he1);
      for (int o = 0; o < 3; o++) if (o != src) fire(o);
      repeat (20) @(posedge clk_sys);
      chk_in("no trigger", 0, 0, n_samp - n0);
      fire(src);
      wait_irq(n);
      chk_in("trig conv", 55, 80, n);
      wr0(adcsq_pkg::ADDR_CTRL_0, 32'h81);
      wr0(adcsq_pkg::ADDR_IRQ, 32'h0);
    end
    $display("test triggers done");
    close_out;
  end
endmodule
